// [status_fifo.sv]
// dual-clock fifo core with standard / fall-through flags and an avalon register port
//
// Overview of operation
// - mode strap caught at reset: low standard
// - standard mode: every word needs a read enable
// - fall-through: first word out after three edges
// - write only when write enable low
// - standard: empty flag rises after first write
// - standard: almost-empty high at offset plus one
// - standard: half-full low at half plus one
// - almost-full low at depth minus full offset
// - standard depth fixed by port width variant
// - standard: full flag low at depth, writes ignored
// - standard: first read after full raises full
// - empty flag low after last read; ignore reads
// - standard: empty/full pass two register stages
// - fall-through: output-ready low after first write
// - fall-through: almost-empty high at offset plus two
// - fall-through: half-full low at half plus two
// - fall-through: capacity depth plus one, input-ready
// - fall-through: first read after full lowers input-ready
// - fall-through: output-ready high after last read
// - output-ready three stages, input-ready two stages
// - default offset pair loaded from select straps
// - flag timing strap: synchronous or split flags
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module status_fifo
   import fifo_flags_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [31:0] avWritedata,
   output logic [31:0] avReaddata,
   output logic avWaitrequest,
   input wire logic timingModeSelect,
   input wire logic loadSelectN,
   input wire logic offsetSelect0,
   input wire logic offsetSelect1,
   input wire logic flagTimingSelect,
   input wire logic writeClk,
   input wire logic writeEnableN,
   input wire logic [fifo_flags_pkg::DATA_W-1:0] writeData,
   input wire logic readClk,
   input wire logic readEnableN,
   output logic [fifo_flags_pkg::DATA_W-1:0] readDataOut,
   output logic emptyFlagN,
   output logic fullFlagN,
   output logic outputReadyN,
   output logic inputReadyN,
   output logic almostEmptyN,
   output logic almostFullN,
   output logic halfFullN
);
   import fifo_flags_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] clkSync;
   logic [DATA_W+1:0] dataSync;
   logic [4:0] strapSync;
   logic wclkPrev_q, rclkPrev_q;
   logic wEdge, rEdge;

   stage_sync #(.W(2), .STAGES(SYNC_STAGES)) u_clkSync (
      .clk(clk), .reset_n(reset_n), .din({writeClk, readClk}), .dout(clkSync));
   // data gets one extra stage so it is sampled from before the detected edge
   stage_sync #(.W(DATA_W + 2), .STAGES(DATA_STAGES)) u_dataSync (
      .clk(clk), .reset_n(reset_n), .din({writeEnableN, readEnableN, writeData}), .dout(dataSync));
   stage_sync #(.W(5), .STAGES(SYNC_STAGES)) u_strapSync (
      .clk(clk), .reset_n(reset_n),
      .din({timingModeSelect, flagTimingSelect, loadSelectN, offsetSelect0, offsetSelect1}),
      .dout(strapSync));

   wire wenN = dataSync[DATA_W+1];
   wire renN = dataSync[DATA_W];
   wire [DATA_W-1:0] wData = dataSync[DATA_W-1:0];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wclkPrev_q <= 1'b0;
         rclkPrev_q <= 1'b0;
      end
      else
      begin
         wclkPrev_q <= clkSync[1];
         rclkPrev_q <= clkSync[0];
      end
   end

   // ----------------------------------------------------------------
   // configuration capture after master reset release
   // ----------------------------------------------------------------
   logic [1:0] cfgCnt_q;
   logic cfgDone_q, fwftMode_q, pfmSync_q;
   logic [OFS_W-1:0] emptyOfs_q, fullOfs_q;

   assign wEdge = clkSync[1] & ~wclkPrev_q & cfgDone_q;
   assign rEdge = clkSync[0] & ~rclkPrev_q & cfgDone_q;
   wire cfgLoad = !cfgDone_q && (cfgCnt_q == CFG_CAPTURE);
   wire regWr = avWrite && cfgDone_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfgCnt_q <= 2'h0;
         cfgDone_q <= 1'b0;
         fwftMode_q <= 1'b0;
         pfmSync_q <= 1'b0;
         emptyOfs_q <= OFS_LLL;
         fullOfs_q <= OFS_LLL;
      end
      else if (cfgLoad)
      begin
         cfgDone_q <= 1'b1;
         fwftMode_q <= strapSync[4];
         pfmSync_q <= strapSync[3];
         emptyOfs_q <= defaultOffset(strapSync[2:0]);
         fullOfs_q <= defaultOffset(strapSync[2:0]);
      end
      else
      begin
         if (!cfgDone_q)
            cfgCnt_q <= cfgCnt_q + 2'h1;
         if (regWr && avAddress == REG_EMPTY_OFS)
            emptyOfs_q <= avWritedata[OFS_W-1:0];
         if (regWr && avAddress == REG_FULL_OFS)
            fullOfs_q <= avWritedata[OFS_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:DEPTH-1];
   logic [PTR_W-1:0] wPtr_q, rPtr_q;
   logic outValid_q;
   logic [1:0] fwCnt_q;
   logic [2*PTR_W:0] xSync;

   stage_sync #(.W(2 * PTR_W + 1), .STAGES(SYNC_STAGES)) u_ptrSync (
      .clk(clk), .reset_n(reset_n),
      .din({bin2gray(wPtr_q), bin2gray(rPtr_q), outValid_q}),
      .dout(xSync));

   wire [PTR_W-1:0] wPtrAtRead = gray2bin(xSync[2*PTR_W:PTR_W+1]);
   wire [PTR_W-1:0] rPtrAtWrite = gray2bin(xSync[PTR_W:1]);
   wire outValidAtWrite = xSync[0];
   wire [PTR_W-1:0] memCountW = wPtr_q - rPtrAtWrite;
   wire [PTR_W-1:0] memCountR = wPtrAtRead - rPtr_q;
   wire memFullW = (memCountW == MEM_FULL_PTR);
   wire memEmptyR = (memCountR == '0);
   wire [CNT_W-1:0] wFill = {1'b0, memCountW} + {18'h00000, fwftMode_q & outValidAtWrite};
   wire [CNT_W-1:0] rFill = {1'b0, memCountR} + {18'h00000, fwftMode_q & outValid_q};
   wire doWrite = wEdge && !wenN && !memFullW;
   wire stdRead = rEdge && !fwftMode_q && !renN && !memEmptyR;
   wire ftRead = rEdge && fwftMode_q && outValid_q && !renN;
   wire ftFirst = rEdge && fwftMode_q && !outValid_q && !memEmptyR;
   wire ftLoad = (ftRead && !memEmptyR) || (ftFirst && fwCnt_q == FIRST_WORD_FALL_THROUGH_LOAD_EDGE);
   wire popMem = stdRead || ftLoad;

   always_ff @(posedge clk)
   begin
      if (doWrite)
         mem[wPtr_q[ADDR_W-1:0]] <= wData;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wPtr_q <= '0;
      else if (doWrite)
         wPtr_q <= wPtr_q + 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rPtr_q <= '0;
         readDataOut <= '0;
      end
      else if (popMem)
      begin
         rPtr_q <= rPtr_q + 1'b1;
         readDataOut <= mem[rPtr_q[ADDR_W-1:0]];
      end
   end

   // the output word counts as one extra entry of capacity in fall-through mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         outValid_q <= 1'b0;
         fwCnt_q <= 2'h0;
      end
      else if (ftLoad)
      begin
         outValid_q <= 1'b1;
         fwCnt_q <= 2'h0;
      end
      else if (ftRead)
         outValid_q <= 1'b0;
      else if (ftFirst)
         fwCnt_q <= fwCnt_q + 2'h1;
   end

   // ----------------------------------------------------------------
   // flag thresholds
   // ----------------------------------------------------------------
   wire [CNT_W-1:0] aeThr = {2'h0, emptyOfs_q} + (fwftMode_q ? EMPTY_STEP_FIRST_WORD_FALL_THROUGH : EMPTY_STEP_STD);
   wire [CNT_W-1:0] afThr = (fwftMode_q ? DEPTH_FIRST_WORD_FALL_THROUGH : DEPTH_STD) - {2'h0, fullOfs_q};
   wire [CNT_W-1:0] hfThr = fwftMode_q ? HALF_FIRST_WORD_FALL_THROUGH : HALF_STD;
   wire [CNT_W-1:0] capThr = fwftMode_q ? DEPTH_FIRST_WORD_FALL_THROUGH : DEPTH_STD;

   // ----------------------------------------------------------------
   // flags: refreshed one cycle after the owning side's clock edge, output-ready at that edge
   // ----------------------------------------------------------------
   logic wUpd_q, rUpd_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wUpd_q <= 1'b0;
         rUpd_q <= 1'b0;
      end
      else
      begin
         wUpd_q <= wEdge;
         rUpd_q <= rEdge;
      end
   end

   // full and input-ready belong to the write side, empty to the read side
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fullFlagN <= 1'b1;
         inputReadyN <= 1'b1;
         emptyFlagN <= 1'b0;
      end
      else
      begin
         if (cfgLoad)
            inputReadyN <= !strapSync[4];
         else if (wUpd_q)
         begin
            fullFlagN <= fwftMode_q || (wFill < capThr);
            inputReadyN <= !fwftMode_q || (wFill >= capThr) || memFullW;
         end
         if (rUpd_q)
            emptyFlagN <= !fwftMode_q && !memEmptyR;
      end
   end

   assign outputReadyN = !(fwftMode_q && outValid_q);

   // split timing: each almost flag is asserted on one side and released on the other
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         almostFullN <= 1'b1;
         almostEmptyN <= 1'b0;
         halfFullN <= 1'b1;
      end
      else
      begin
         if (wUpd_q)
            halfFullN <= wFill < hfThr;
         else if (rUpd_q)
            halfFullN <= rFill < hfThr;
         // both sides may refresh in one cycle: the owning side's assert beats the other side's release
         if (wUpd_q && (pfmSync_q || wFill >= afThr))
            almostFullN <= wFill < afThr;
         else if (rUpd_q && !pfmSync_q && rFill < afThr)
            almostFullN <= 1'b1;
         if (rUpd_q && (pfmSync_q || rFill < aeThr))
            almostEmptyN <= rFill >= aeThr;
         else if (wUpd_q && !pfmSync_q && wFill >= aeThr)
            almostEmptyN <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // avalon-mm slave: reads take one wait state, writes none
   // ----------------------------------------------------------------
   logic rdAck_q;
   wire [31:0] statusWord = {21'h000000, cfgDone_q, pfmSync_q, fwftMode_q, 1'b0, inputReadyN, outputReadyN,
                             halfFullN, almostFullN, almostEmptyN, fullFlagN, emptyFlagN};
   wire [31:0] rdMux = (avAddress == REG_STATUS) ? statusWord :
                       (avAddress == REG_EMPTY_OFS) ? {15'h0000, emptyOfs_q} :
                       (avAddress == REG_FULL_OFS) ? {15'h0000, fullOfs_q} :
                       (avAddress == REG_FILL) ? {13'h0000, rFill} : 32'h00000000;

   assign avWaitrequest = avRead && !rdAck_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdAck_q <= 1'b0;
         avReaddata <= 32'h00000000;
      end
      else
      begin
         rdAck_q <= avRead && !rdAck_q;
         if (avRead && !rdAck_q)
            avReaddata <= rdMux;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_mode_stays_put: assert property (cfgDone_q |=> $stable(fwftMode_q))
      else $error("timing mode changed after capture");
   a_write_advances: assert property (doWrite |=> wPtr_q == PTR_W'($past(wPtr_q) + 1'b1))
      else $error("accepted write did not advance the write pointer");
   a_full_blocks_write: assert property (wEdge && memFullW |=> $stable(wPtr_q))
      else $error("write taken while storage full");
   a_empty_blocks_read: assert property (rEdge && memEmptyR && !outValid_q |=> $stable(rPtr_q))
      else $error("read taken while empty");
   a_empty_flag_high: assert property (!fwftMode_q && rEdge && renN && !memEmptyR |=> ##1 emptyFlagN)
      else $error("empty flag stayed low with data stored");
   a_full_flag_low: assert property (!fwftMode_q && wEdge && wFill == DEPTH_STD |=> ##1 !fullFlagN)
      else $error("full flag not low at full depth");
   a_first_word_third: assert property (ftFirst && fwCnt_q != FIRST_WORD_FALL_THROUGH_LOAD_EDGE |=> outputReadyN)
      else $error("first word shown before third read clock edge");
   a_ready_on_load: assert property (ftLoad |=> !outputReadyN && rPtr_q == PTR_W'($past(rPtr_q) + 1'b1))
      else $error("output ready not asserted after load");
   a_half_full_low: assert property (wEdge ##1 (wUpd_q && wFill >= hfThr) |=> !halfFullN)
      else $error("half full flag not low above half depth");
   a_read_wait_once: assert property (avRead && avWaitrequest |=> !avWaitrequest)
      else $error("register read stalled more than one cycle");

   c_std_write: cover property (!fwftMode_q && doWrite ##[1:200] stdRead);
   c_first_word_fall_through_first: cover property (ftLoad && fwCnt_q == FIRST_WORD_FALL_THROUGH_LOAD_EDGE);
   c_almost_empty_rise: cover property ($rose(almostEmptyN));
   c_reg_write: cover property (regWr && avAddress == REG_EMPTY_OFS);
endmodule

// [fifo_flags_pkg.sv]
// constants, field layouts and helper functions for the dual-clock status-flag fifo
package fifo_flags_pkg;

   // ----------------------------------------------------------------
   // storage geometry (both ports 18 bits wide, smaller size variant)
   // ----------------------------------------------------------------
   localparam int DATA_W = 18;
   localparam int ADDR_W = 17;
   localparam int PTR_W = 18;
   localparam int CNT_W = 19;
   localparam int OFS_W = 17;
   localparam int DEPTH = 131072;
   localparam logic [PTR_W-1:0] MEM_FULL_PTR = 18'h20000;
   localparam logic [CNT_W-1:0] DEPTH_STD = 19'h20000;
   localparam logic [CNT_W-1:0] DEPTH_FIRST_WORD_FALL_THROUGH = 19'h20001;
   localparam logic [CNT_W-1:0] HALF_STD = 19'h10001;
   localparam logic [CNT_W-1:0] HALF_FIRST_WORD_FALL_THROUGH = 19'h10002;
   localparam logic [CNT_W-1:0] EMPTY_STEP_STD = 19'h00001;
   localparam logic [CNT_W-1:0] EMPTY_STEP_FIRST_WORD_FALL_THROUGH = 19'h00002;

   // ----------------------------------------------------------------
   // synchroniser depths and configuration capture
   // ----------------------------------------------------------------
   localparam int SYNC_STAGES = 2;
   localparam int DATA_STAGES = 3;
   localparam logic [1:0] CFG_CAPTURE = 2'h2;
   localparam logic [1:0] FIRST_WORD_FALL_THROUGH_LOAD_EDGE = 2'h2;

   // ----------------------------------------------------------------
   // default offsets, picked by {load_select_n, offset_select_0, offset_select_1}
   // ----------------------------------------------------------------
   localparam logic [OFS_W-1:0] OFS_LLL = 17'h0007F;
   localparam logic [OFS_W-1:0] OFS_LLH = 17'h03FFF;
   localparam logic [OFS_W-1:0] OFS_LHL = 17'h01FFF;
   localparam logic [OFS_W-1:0] OFS_LHH = 17'h00FFF;
   localparam logic [OFS_W-1:0] OFS_HLL = 17'h003FF;
   localparam logic [OFS_W-1:0] OFS_HLH = 17'h007FF;
   localparam logic [OFS_W-1:0] OFS_HHL = 17'h001FF;
   localparam logic [OFS_W-1:0] OFS_HHH = 17'h000FF;

   // ----------------------------------------------------------------
   // avalon register map and status fields
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_EMPTY_OFS = 4'h4;
   localparam logic [3:0] REG_FULL_OFS = 4'h8;
   localparam logic [3:0] REG_FILL = 4'hC;
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_AEMPTY = 2;
   localparam int ST_AFULL = 3;
   localparam int ST_HALF = 4;
   localparam int ST_ORDY = 5;
   localparam int ST_IRDY = 6;
   localparam int ST_FIRST_WORD_FALL_THROUGH = 8;
   localparam int ST_PFM = 9;
   localparam int ST_CFG = 10;

   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction

   function automatic logic [OFS_W-1:0] defaultOffset(input logic [2:0] sel);
      case (sel)
         3'h0: return OFS_LLL;
         3'h1: return OFS_LLH;
         3'h2: return OFS_LHL;
         3'h3: return OFS_LHH;
         3'h4: return OFS_HLL;
         3'h5: return OFS_HLH;
         3'h6: return OFS_HHL;
         default: return OFS_HHH;
      endcase
   endfunction

endpackage

// [stage_sync.sv]
// multi-stage register chain used to bring pins and pointers into the clk domain
`timescale 1ns/1ns
module stage_sync #(
   parameter int W = 1,
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] chain_q [0:STAGES-1];

   // ----------------------------------------------------------------
   // the first stage feeds only the second; nothing else looks at it
   // ----------------------------------------------------------------
   generate
      for (genvar s = 0; s < STAGES; s++)
      begin : g_stage
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               chain_q[s] <= '0;
            else if (s == 0)
               chain_q[s] <= din;
            else
               chain_q[s] <= chain_q[(s == 0) ? 0 : s - 1];
         end
      end
   endgenerate

   assign dout = chain_q[STAGES-1];
endmodule

// [fifo_link_model.sv]
// writer and reader logic on the link side of the fifo, each with its own pin clock
`timescale 1ns/1ns
module fifo_link_model (
   input wire logic clk,
   output logic writeClk,
   output logic writeEnableN,
   output logic [fifo_flags_pkg::DATA_W-1:0] writeData,
   output logic readClk,
   output logic readEnableN,
   input wire logic [fifo_flags_pkg::DATA_W-1:0] readDataOut
);
   import fifo_flags_pkg::*;

   initial
   begin
      writeClk = 1'b0;
      writeEnableN = 1'b1;
      writeData = '0;
      readClk = 1'b0;
      readEnableN = 1'b1;
   end

   // ----------------------------------------------------------------
   // one 62 ns pin clock pulse per transfer
   // ----------------------------------------------------------------
   // the pin clocks stand still between transfers, as a gated link clock would
   // each transfer starts on a falling clk edge so no pin moves on a sampling edge
   task automatic push(input logic [DATA_W-1:0] d, input logic en);
      @(negedge clk);
      writeEnableN = !en;
      writeData = d;
      #61 writeClk = 1'b1;
      #62 writeClk = 1'b0;
      writeEnableN = 1'b1;
      // released data lines are scrambled so a stale word cannot pass for a good one
      writeData = ~d;
      #2;
   endtask

   // read data is taken at the falling edge, long after the flags settle
   task automatic pull(input logic en, output logic [DATA_W-1:0] q);
      @(negedge clk);
      readEnableN = !en;
      #61 readClk = 1'b1;
      #62 readClk = 1'b0;
      q = readDataOut;
      readEnableN = 1'b1;
      #2;
   endtask
endmodule

// [dual_clock_fifo_status_flags_tb_top.sv]
// self-checking bench: straps, register port and link traffic in both timing modes
`timescale 1ns/1ns
module dual_clock_fifo_status_flags_tb_top;
   import fifo_flags_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avAddress = 4'h0;
   logic avRead = 1'b0;
   logic avWrite = 1'b0;
   logic [31:0] avWritedata = 32'h0;
   logic [31:0] avReaddata;
   logic avWaitrequest;
   logic [4:0] straps = 5'h00;
   logic writeClk, writeEnableN, readClk, readEnableN;
   logic [DATA_W-1:0] writeData, readDataOut, q;
   logic emptyFlagN, fullFlagN, outputReadyN, inputReadyN, almostEmptyN, almostFullN, halfFullN;
   logic [31:0] rd;
   logic [DATA_W-1:0] wd [4] = '{18'h3A5C1, 18'h05A3E, 18'h2FFFF, 18'h10000};
   logic [6:0] stdExp [4] = '{7'h7F, 7'h6F, 7'h6F, 7'h2F};
   int err_count = 0;
   int cmp_count = 0;
   // flag order: empty, full, almost-empty, almost-full, half, output-ready, input-ready
   wire logic [6:0] flags = {emptyFlagN, fullFlagN, almostEmptyN, almostFullN, halfFullN, outputReadyN, inputReadyN};

   always #2 clk = ~clk;

   status_fifo u_dut (
      .clk(clk), .reset_n(reset_n), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
      .avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
      .timingModeSelect(straps[4]), .loadSelectN(straps[3]), .offsetSelect0(straps[2]),
      .offsetSelect1(straps[1]), .flagTimingSelect(straps[0]),
      .writeClk(writeClk), .writeEnableN(writeEnableN), .writeData(writeData),
      .readClk(readClk), .readEnableN(readEnableN), .readDataOut(readDataOut),
      .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .outputReadyN(outputReadyN),
      .inputReadyN(inputReadyN), .almostEmptyN(almostEmptyN), .almostFullN(almostFullN),
      .halfFullN(halfFullN)
   );

   fifo_link_model u_link (
      .clk(clk),
      .writeClk(writeClk), .writeEnableN(writeEnableN), .writeData(writeData),
      .readClk(readClk), .readEnableN(readEnableN), .readDataOut(readDataOut)
   );

   // ----------------------------------------------------------------
   // compare, bus and reset tasks
   // ----------------------------------------------------------------
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkFlags(input logic [6:0] exp);
      cmp_count++;
      if (flags !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, flags, exp);
      end
   endtask

   // the request stands until the edge at which waitrequest is sampled low; that edge takes it
   task automatic avRd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      avAddress <= a;
      avRead <= 1'b1;
      @(posedge clk);
      while (avWaitrequest !== 1'b0)
         @(posedge clk);
      d = avReaddata;
      avRead <= 1'b0;
   endtask

   task automatic avWr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avAddress <= a;
      avWritedata <= d;
      avWrite <= 1'b1;
      @(posedge clk);
      while (avWaitrequest !== 1'b0)
         @(posedge clk);
      avWrite <= 1'b0;
   endtask

   // straps: mode, load select, offset select 0 and 1, flag timing
   task automatic doReset(input logic [4:0] s);
      @(posedge clk);
      reset_n <= 1'b0;
      straps <= s;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   task automatic close_out;
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #60000;
      err_count++;
      close_out();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      doReset(5'h00);
      chkFlags(7'h2F);
      avRd(REG_EMPTY_OFS, rd);
      chkWord(rd, 32'h0000007F);
      avRd(REG_FULL_OFS, rd);
      chkWord(rd, 32'h0000007F);
      avRd(4'h6, rd);
      chkWord(rd, 32'h00000000);
      avWr(REG_EMPTY_OFS, 32'h00000002);
      avWr(REG_FULL_OFS, 32'h0001FFFC);
      avRd(REG_FULL_OFS, rd);
      chkWord(rd, 32'h0001FFFC);
      u_link.push(wd[0], 1'b1);
      // the empty flag lives on the read side and needs a read clock edge to refresh
      u_link.pull(1'b0, q);
      chkWord(32'(q), 32'h00000000);
      chkFlags(7'h6F);
      u_link.push(wd[1], 1'b1);
      u_link.push(wd[2], 1'b1);
      chkFlags(7'h7F);
      u_link.push(wd[3], 1'b1);
      chkFlags(7'h77);
      u_link.push(18'h00000, 1'b0);
      avRd(REG_FILL, rd);
      chkWord(rd, 32'h00000004);
      u_link.pull(1'b0, q);
      chkWord(32'(q), 32'h00000000);
      for (int i = 0; i < 4; i++)
      begin
         u_link.pull(1'b1, q);
         chkWord(32'(q), 32'(wd[i]));
         chkFlags(stdExp[i]);
      end
      u_link.pull(1'b1, q);
      chkWord(32'(q), 32'(wd[3]));
      avRd(REG_FILL, rd);
      chkWord(rd, 32'h00000000);
      $display("test standard_mode done");

      // fall-through timing, synchronous almost flags, default offset 2047
      doReset(5'h1B);
      chkFlags(7'h2E);
      avRd(REG_EMPTY_OFS, rd);
      chkWord(rd, 32'h000007FF);
      avRd(REG_STATUS, rd);
      chkWord(rd & 32'h00000700, 32'h00000700);
      avWr(REG_EMPTY_OFS, 32'h00000002);
      avWr(REG_FULL_OFS, 32'h0001FFFD);
      u_link.push(wd[0], 1'b1);
      u_link.pull(1'b0, q);
      u_link.pull(1'b0, q);
      chkFlags(7'h2E);
      u_link.pull(1'b0, q);
      chkWord(32'(q), 32'(wd[0]));
      chkFlags(7'h2C);
      u_link.push(wd[1], 1'b1);
      u_link.push(wd[2], 1'b1);
      chkFlags(7'h2C);
      u_link.push(wd[3], 1'b1);
      chkFlags(7'h24);
      u_link.pull(1'b0, q);
      chkFlags(7'h34);
      u_link.pull(1'b1, q);
      chkWord(32'(q), 32'(wd[1]));
      chkFlags(7'h24);
      u_link.push(wd[0], 1'b0);
      chkFlags(7'h2C);
      for (int i = 2; i < 4; i++)
      begin
         u_link.pull(1'b1, q);
         chkWord(32'(q), 32'(wd[i]));
      end
      u_link.pull(1'b1, q);
      chkFlags(7'h2E);
      u_link.pull(1'b1, q);
      chkFlags(7'h2E);
      $display("test fall_through_mode done");
      close_out();
   end
endmodule
